/* File: octal_gcr_defs.svh */
// Offsets, field positions and reset values of the global register bank.
// Assumes an 8-bit host address split into channel windows and one page.
// Function
// RULE_01: Eight channels each own one 16-byte window, channel N at N*0x10.
// RULE_02: All registers share one 256-byte space decoded from eight lines.
// RULE_03: Global registers answer at 0x80 to 0x8F, needing no indirection.
// RULE_04: Lowest eight locations of each window keep the legacy UART set.
// RULE_05: Byte 0x80 shows one pending-service bit per channel.
// RULE_06: Bytes 0x81 to 0x83 pack 3-bit source codes from channel 0 upward.
// RULE_07: 0x84 holds four control bits, 0x85 reads zero, 0x86/0x87 reload.
// RULE_08: 0x88 and 0x89 select 8x or 4x sampling; neither means 16x.
// RULE_09: Writing one to bit N of 0x8A resets only channel N.
// RULE_10: Byte 0x8B holds one sleep-enable bit per channel.
// RULE_11: Bit 0 of 0x8E makes channel writes reach all eight channels.
// RULE_12: 0x8C and 0x8D return fixed revision and identity; writes ignored.
// RULE_13: Channels keep own registers; bank steers them only via its bits.
// RULE_14: Host uses plain single-byte reads and writes, no unlock sequence.
// RULE_15: Codes: 0 none, 1 rx, 2 timeout, 3 tx, 4 modem, 7 timer on ch0.
// RULE_16: Timer value bytes read back the programmed value, not the count.
// RULE_17: Sleep only when sleep byte is all ones and nothing is pending.
// RULE_18: Address 0x8F reads zero and ignores writes.
`ifndef OCTAL_GCR_DEFS_SVH
`define OCTAL_GCR_DEFS_SVH
`define CHAN_SPACE_BIT 7
`define CHAN_IDX_MSB 6
`define CHAN_IDX_LSB 4
`define GLOBAL_PAGE 4'h8
`define LEGACY_TOP 4'h7
`define ADDR_IRQ_PENDING 8'h80
`define ADDR_CODE_WORD0 8'h81
`define ADDR_CODE_WORD1 8'h82
`define ADDR_CODE_WORD2 8'h83
`define ADDR_CNT_CONTROL 8'h84
`define ADDR_CNT_RESERVED 8'h85
`define ADDR_CNT_LOW 8'h86
`define ADDR_CNT_HIGH 8'h87
`define ADDR_EIGHTFOLD 8'h88
`define ADDR_FOURFOLD 8'h89
`define ADDR_SOFT_RESET 8'h8a
`define ADDR_SLEEP 8'h8b
`define ADDR_REVISION 8'h8c
`define ADDR_IDENTITY 8'h8d
`define ADDR_BROADCAST 8'h8e
`define BCAST_BIT 0
`define CNT_CTRL_W 4
`define CODE_TIMER 3'h7
`define CODE_NONE 3'h0
`define SLEEP_ALL 8'hff
`define RST_BYTE 8'h00
`define RST_CNT_CTRL 4'h0
`define RST_RELOAD 16'h0000
`define RST_PINS 19'h7ffff
`endif

/* File: octal_gcr_pkg.sv */
// Types shared by the host front end and the register bank.
// Assumes nothing beyond the defs header for numbers.
package octal_gcr_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0]
    {
        ACC_NONE = 3'b001,
        ACC_READ = 3'b010,
        ACC_WRITE = 3'b100
    } access_e;
endpackage

/* File: host_access_if.sv */
// Decoded host accesses passed from the pin front end to the bank.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface host_access_if;
    logic rd_start;
    logic rd_active;
    logic wr_pulse;
    octal_gcr_pkg::byte_t addr;
    octal_gcr_pkg::byte_t wdata;
    modport front
    (
        output rd_start,
        output rd_active,
        output wr_pulse,
        output addr,
        output wdata
    );
    modport bank
    (
        input rd_start,
        input rd_active,
        input wr_pulse,
        input addr,
        input wdata
    );
endinterface

/* File: host_bus_front.sv */
// Synchronises the host strobes, address and data pins and turns them
// into one read start, a read-active level and one write pulse.
// Assumes pins are asynchronous to ref_clk and held stable while strobed.
`timescale 1ns/100ps
`include "octal_gcr_defs.svh"
module host_bus_front
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] register_address_lines,
    input wire logic [7:0] host_data_in,
    host_access_if.front acc
);
    logic [18:0] sync1_ff;
    logic [18:0] sync2_ff;
    logic [18:0] nxt_sync1;
    logic [18:0] nxt_sync2;
    octal_gcr_pkg::access_e state_ff;
    octal_gcr_pkg::access_e nxt_state;
    logic rd_start_ff;
    logic nxt_rd_start;
    logic wr_pulse_ff;
    logic nxt_wr_pulse;
    octal_gcr_pkg::byte_t addr_ff;
    octal_gcr_pkg::byte_t nxt_addr;
    octal_gcr_pkg::byte_t wdata_ff;
    octal_gcr_pkg::byte_t nxt_wdata;
    logic rd_req;
    logic wr_req;

    always_comb
    begin
        nxt_sync1 = {host_cs_n, host_rd_n, host_wr_n,
                     register_address_lines, host_data_in};
        nxt_sync2 = sync1_ff;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= `RST_PINS;
            sync2_ff <= `RST_PINS;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // Only the second stage is decoded
    assign rd_req = !sync2_ff[18] && !sync2_ff[17];
    assign wr_req = !sync2_ff[18] && !sync2_ff[16];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rd_start = 1'b0;
        nxt_wr_pulse = 1'b0;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        unique case (state_ff)
            octal_gcr_pkg::ACC_NONE:
            begin
                // Any single access is served directly [RULE_14]
                if (rd_req)
                begin
                    nxt_state = octal_gcr_pkg::ACC_READ;
                    nxt_rd_start = 1'b1;
                    nxt_addr = sync2_ff[15:8];
                end
                else if (wr_req)
                begin
                    nxt_state = octal_gcr_pkg::ACC_WRITE;
                    nxt_addr = sync2_ff[15:8];
                    nxt_wdata = sync2_ff[7:0];
                end
            end
            octal_gcr_pkg::ACC_READ:
            begin
                if (!rd_req)
                    nxt_state = octal_gcr_pkg::ACC_NONE;
            end
            octal_gcr_pkg::ACC_WRITE:
            begin
                // Data is taken while the strobe stands, acted on at its end
                if (wr_req)
                begin
                    nxt_addr = sync2_ff[15:8];
                    nxt_wdata = sync2_ff[7:0];
                end
                else
                begin
                    nxt_state = octal_gcr_pkg::ACC_NONE;
                    nxt_wr_pulse = 1'b1;
                end
            end
            default:
                nxt_state = octal_gcr_pkg::ACC_NONE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= octal_gcr_pkg::ACC_NONE;
            rd_start_ff <= 1'b0;
            wr_pulse_ff <= 1'b0;
            addr_ff <= `RST_BYTE;
            wdata_ff <= `RST_BYTE;
        end
        else
        begin
            state_ff <= nxt_state;
            rd_start_ff <= nxt_rd_start;
            wr_pulse_ff <= nxt_wr_pulse;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
        end
    end

    assign acc.rd_start = rd_start_ff;
    assign acc.rd_active = (state_ff == octal_gcr_pkg::ACC_READ);
    assign acc.wr_pulse = wr_pulse_ff;
    assign acc.addr = addr_ff;
    assign acc.wdata = wdata_ff;
endmodule

/* File: octal_uart_global_config_regs.sv */
// Global configuration bank of an eight-channel UART with the host
// address decode for the channel windows.
// Assumes channel logic on ref_clk supplies flags, codes and read data,
// and the host drives the parallel bus pins asynchronously.
`timescale 1ns/100ps
`include "octal_gcr_defs.svh"
module octal_uart_global_config_regs
#(
    // Arbitrary values, not those of any real part
    parameter logic [7:0] REVISION_CODE = 8'h01,
    parameter logic [7:0] IDENTITY_CODE = 8'h5a
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] register_address_lines,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic [7:0] per_channel_irq_flags,
    input wire logic [23:0] chan_irq_code,
    input wire logic timer_timeout,
    input wire logic [63:0] chan_rd_data,
    output logic [7:0] chan_sel,
    output logic [3:0] chan_reg_index,
    output logic [7:0] chan_wr_data,
    output logic chan_wr_strobe,
    output logic chan_rd_strobe,
    output logic chan_legacy_access,
    output logic [7:0] chan_soft_reset,
    output logic [7:0] eightfold_sampling_select,
    output logic [7:0] fourfold_sampling_select,
    output logic [7:0] channel_sleep_enable,
    output logic sleep_request,
    output logic [3:0] counter_control_reg,
    output logic [15:0] timer_reload,
    output logic counter_control_read
);
    host_access_if acc ();

    host_bus_front u_front
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n),
        .register_address_lines(register_address_lines),
        .host_data_in(host_data_in),
        .acc(acc)
    );

    // Address decode
    logic in_chan_space;
    logic in_global_page;
    logic [2:0] chan_idx;
    logic glob_wr;
    logic chan_wr;
    logic chan_rd;

    always_comb
    begin
        // Bit 7 clear means one of eight 16-byte windows [RULE_01] [RULE_02]
        in_chan_space = !acc.addr[`CHAN_SPACE_BIT];
        chan_idx = acc.addr[`CHAN_IDX_MSB:`CHAN_IDX_LSB];
        // Global page needs no channel select [RULE_03]
        in_global_page = (acc.addr[7:4] == `GLOBAL_PAGE);
        glob_wr = acc.wr_pulse && in_global_page;
        chan_wr = acc.wr_pulse && in_chan_space;
        chan_rd = acc.rd_start && in_chan_space;
    end

    // Writable global registers
    logic [`CNT_CTRL_W-1:0] cnt_ctrl_ff;
    logic [`CNT_CTRL_W-1:0] nxt_cnt_ctrl;
    logic [15:0] reload_ff;
    logic [15:0] nxt_reload;
    logic [7:0] eight_ff;
    logic [7:0] nxt_eight;
    logic [7:0] four_ff;
    logic [7:0] nxt_four;
    logic [7:0] sleep_ff;
    logic [7:0] nxt_sleep;
    logic bcast_ff;
    logic nxt_bcast;
    logic [7:0] soft_rst_ff;
    logic [7:0] nxt_soft_rst;

    always_comb
    begin
        nxt_cnt_ctrl = cnt_ctrl_ff;
        nxt_reload = reload_ff;
        nxt_eight = eight_ff;
        nxt_four = four_ff;
        nxt_sleep = sleep_ff;
        nxt_bcast = bcast_ff;
        nxt_soft_rst = `RST_BYTE;
        if (glob_wr)
        begin
            unique case (acc.addr)
                `ADDR_CNT_CONTROL:
                    nxt_cnt_ctrl = acc.wdata[`CNT_CTRL_W-1:0]; // [RULE_07]
                `ADDR_CNT_LOW:
                    nxt_reload[7:0] = acc.wdata; // [RULE_07]
                `ADDR_CNT_HIGH:
                    nxt_reload[15:8] = acc.wdata; // [RULE_07]
                `ADDR_EIGHTFOLD:
                    nxt_eight = acc.wdata; // [RULE_08]
                `ADDR_FOURFOLD:
                    nxt_four = acc.wdata; // [RULE_08]
                `ADDR_SOFT_RESET:
                    nxt_soft_rst = acc.wdata; // [RULE_09]
                `ADDR_SLEEP:
                    nxt_sleep = acc.wdata; // [RULE_10]
                `ADDR_BROADCAST:
                    nxt_bcast = acc.wdata[`BCAST_BIT]; // [RULE_11]
                default:
                    // Status, identity and 0x8F writes fall away
                    nxt_bcast = bcast_ff; // [RULE_12] [RULE_18]
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ctrl_ff <= `RST_CNT_CTRL;
            reload_ff <= `RST_RELOAD;
            eight_ff <= `RST_BYTE;
            four_ff <= `RST_BYTE;
            sleep_ff <= `RST_BYTE;
            bcast_ff <= 1'b0;
            soft_rst_ff <= `RST_BYTE;
        end
        else
        begin
            cnt_ctrl_ff <= nxt_cnt_ctrl;
            reload_ff <= nxt_reload;
            eight_ff <= nxt_eight;
            four_ff <= nxt_four;
            sleep_ff <= nxt_sleep;
            bcast_ff <= nxt_bcast;
            soft_rst_ff <= nxt_soft_rst;
        end
    end

    // Interrupt view of the channels
    logic [7:0] pending;
    logic [23:0] codes;

    always_comb
    begin
        codes = chan_irq_code;
        // Timer is the lowest priority source, seen on channel 0 only
        if (timer_timeout && chan_irq_code[2:0] == `CODE_NONE)
            codes[2:0] = `CODE_TIMER; // [RULE_15]
        pending = per_channel_irq_flags;
        pending[0] = per_channel_irq_flags[0] || timer_timeout; // [RULE_05]
    end

    // Channel access strobes
    logic [7:0] sel_ff;
    logic [7:0] nxt_sel;
    logic [3:0] reg_idx_ff;
    logic [3:0] nxt_reg_idx;
    logic [7:0] cwdata_ff;
    logic [7:0] nxt_cwdata;
    logic cwr_ff;
    logic nxt_cwr;
    logic crd_ff;
    logic nxt_crd;
    logic legacy_ff;
    logic nxt_legacy;

    always_comb
    begin
        nxt_sel = `RST_BYTE;
        nxt_reg_idx = reg_idx_ff;
        nxt_cwdata = cwdata_ff;
        nxt_cwr = chan_wr;
        nxt_crd = chan_rd;
        nxt_legacy = legacy_ff;
        if (chan_wr || chan_rd)
        begin
            // Each channel keeps its own set; only the window is chosen
            nxt_sel[chan_idx] = 1'b1; // [RULE_13]
            if (chan_wr && bcast_ff)
                nxt_sel = 8'hff; // [RULE_11]
            nxt_reg_idx = acc.addr[3:0];
            // Low eight locations go to the legacy register set
            nxt_legacy = (acc.addr[3:0] <= `LEGACY_TOP); // [RULE_04]
            nxt_cwdata = acc.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_ff <= `RST_BYTE;
            reg_idx_ff <= 4'h0;
            cwdata_ff <= `RST_BYTE;
            cwr_ff <= 1'b0;
            crd_ff <= 1'b0;
            legacy_ff <= 1'b0;
        end
        else
        begin
            sel_ff <= nxt_sel;
            reg_idx_ff <= nxt_reg_idx;
            cwdata_ff <= nxt_cwdata;
            cwr_ff <= nxt_cwr;
            crd_ff <= nxt_crd;
            legacy_ff <= nxt_legacy;
        end
    end

    // Read path
    logic [7:0] rdata;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic oe_ff;
    logic nxt_oe;
    logic cnt_rd_ff;
    logic nxt_cnt_rd;
    logic sleep_req_ff;
    logic nxt_sleep_req;

    always_comb
    begin
        rdata = `RST_BYTE;
        if (in_chan_space)
            rdata = chan_rd_data[{chan_idx, 3'h0} +: 8];
        else if (in_global_page)
        begin
            unique case (acc.addr)
                `ADDR_IRQ_PENDING:
                    rdata = pending; // [RULE_05]
                `ADDR_CODE_WORD0:
                    rdata = codes[7:0]; // [RULE_06]
                `ADDR_CODE_WORD1:
                    rdata = codes[15:8]; // [RULE_06]
                `ADDR_CODE_WORD2:
                    rdata = codes[23:16]; // [RULE_06]
                `ADDR_CNT_CONTROL:
                    rdata = {4'h0, cnt_ctrl_ff}; // [RULE_07]
                `ADDR_CNT_LOW:
                    rdata = reload_ff[7:0]; // [RULE_16]
                `ADDR_CNT_HIGH:
                    rdata = reload_ff[15:8]; // [RULE_16]
                `ADDR_EIGHTFOLD:
                    rdata = eight_ff;
                `ADDR_FOURFOLD:
                    rdata = four_ff;
                `ADDR_SLEEP:
                    rdata = sleep_ff;
                `ADDR_REVISION:
                    rdata = REVISION_CODE; // [RULE_12]
                `ADDR_IDENTITY:
                    rdata = IDENTITY_CODE; // [RULE_12]
                `ADDR_BROADCAST:
                    rdata = {7'h00, bcast_ff}; // [RULE_11]
                default:
                    // 0x85, write-only 0x8A and 0x8F read zero
                    rdata = `RST_BYTE; // [RULE_07] [RULE_18]
            endcase
        end
        nxt_rdata = acc.rd_active ? rdata : `RST_BYTE;
        nxt_oe = acc.rd_active;
        // Reading the control byte lets the timer clear its flag
        nxt_cnt_rd = acc.rd_start && (acc.addr == `ADDR_CNT_CONTROL);
        // Pending work always holds the device awake [RULE_17]
        nxt_sleep_req = (sleep_ff == `SLEEP_ALL) && (pending == `RST_BYTE);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= `RST_BYTE;
            oe_ff <= 1'b0;
            cnt_rd_ff <= 1'b0;
            sleep_req_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            oe_ff <= nxt_oe;
            cnt_rd_ff <= nxt_cnt_rd;
            sleep_req_ff <= nxt_sleep_req;
        end
    end

    assign host_data_out = rdata_ff;
    assign host_data_oe = oe_ff;
    assign chan_sel = sel_ff;
    assign chan_reg_index = reg_idx_ff;
    assign chan_wr_data = cwdata_ff;
    assign chan_wr_strobe = cwr_ff;
    assign chan_rd_strobe = crd_ff;
    assign chan_legacy_access = legacy_ff;
    assign chan_soft_reset = soft_rst_ff;
    assign eightfold_sampling_select = eight_ff;
    assign fourfold_sampling_select = four_ff;
    assign channel_sleep_enable = sleep_ff;
    assign sleep_request = sleep_req_ff;
    assign counter_control_reg = cnt_ctrl_ff;
    assign timer_reload = reload_ff;
    assign counter_control_read = cnt_rd_ff;
endmodule

/* File: octal_gcr_checker.sv */
// Port-level checker of the global register bank.
// Assumes a bind into the top module; sees only its ports.
`timescale 1ns/100ps
module octal_gcr_checker
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic [7:0] per_channel_irq_flags,
    input wire logic timer_timeout,
    input wire logic [7:0] chan_sel,
    input wire logic [3:0] chan_reg_index,
    input wire logic chan_wr_strobe,
    input wire logic chan_rd_strobe,
    input wire logic chan_legacy_access,
    input wire logic [7:0] chan_soft_reset,
    input wire logic [7:0] channel_sleep_enable,
    input wire logic sleep_request,
    input wire logic counter_control_read
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sleep_ok;
        channel_sleep_enable == 8'hff && per_channel_irq_flags == 8'h00
            && !timer_timeout;
    endsequence
    sequence sleep_blocked;
        channel_sleep_enable != 8'hff || per_channel_irq_flags != 8'h00;
    endsequence
    chk_sleep_enter: assert property
        (sleep_ok [*3] |-> sleep_request) else $error("sleep missing");
    chk_sleep_block: assert property
        (sleep_blocked [*3] |-> !sleep_request) else $error("sleep blocked");
    chk_oe_cause: assert property
        ($rose(host_data_oe) |-> $past(!host_cs_n && !host_rd_n, 2))
        else $error("drive without read");
    chk_idle_quiet: assert property
        (host_rd_n [*5] |-> !host_data_oe && host_data_out == 8'h00)
        else $error("drive after read");
    chk_wr_pulse: assert property
        (chan_wr_strobe |=> !chan_wr_strobe) else $error("long write strobe");
    chk_sel_shape: assert property
        (chan_wr_strobe |-> $onehot(chan_sel) || chan_sel == 8'hff)
        else $error("bad write select");
    chk_rd_select: assert property
        (chan_rd_strobe |-> $onehot(chan_sel) && host_data_oe)
        else $error("bad read select");
    chk_srst_pulse: assert property
        (|chan_soft_reset |=> chan_soft_reset == 8'h00)
        else $error("long soft reset");
    chk_legacy_flag: assert property
        (chan_wr_strobe || chan_rd_strobe |=>
        chan_legacy_access == !chan_reg_index[3])
        else $error("bad legacy flag");
    chk_ctrl_read: assert property
        (counter_control_read |-> host_data_oe ##1 !counter_control_read)
        else $error("bad control read");
    chk_wr_no_drive: assert property
        (chan_wr_strobe |-> !host_data_oe) else $error("drive during write");
endmodule

/* File: host_cpu_model.sv */
// Host processor model on the parallel register bus.
// Assumes pins change at falling edges of ref_clk.
`timescale 1ns/100ps
module host_cpu_model
(
    input wire logic ref_clk,
    output logic host_cs_n,
    output logic host_rd_n,
    output logic host_wr_n,
    output logic [7:0] register_address_lines,
    output logic [7:0] host_data_in,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe
);
    initial
    begin
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        {register_address_lines, host_data_in} = 16'h0000;
    end
    // Plain single-byte cycle
    task automatic access(input logic [7:0] a, input logic [7:0] d,
        input logic rd, output logic [7:0] q, output logic oe);
        @(negedge ref_clk);
        {register_address_lines, host_data_in} = {a, d};
        host_cs_n = 1'b0;
        host_rd_n = !rd;
        host_wr_n = rd;
        repeat (5) @(negedge ref_clk);
        q = host_data_out;
        oe = host_data_oe;
        {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
        // Inverted address and data after the hold
        repeat (3) @(negedge ref_clk);
        {register_address_lines, host_data_in} = ~{a, d};
        repeat (2) @(negedge ref_clk);
    endtask
endmodule

/* File: octal_uart_global_config_regs_tb.sv */
// Self-checking bench for the global register bank.
// Assumes host model and checker compiled alongside.
`timescale 1ns/100ps
module octal_uart_global_config_regs_tb;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary value
    localparam logic [7:0] IDC = 8'ha7; // Arbitrary value
    logic ref_clk, rst, host_cs_n, host_rd_n, host_wr_n, host_data_oe;
    logic [7:0] register_address_lines, host_data_in, host_data_out;
    logic [7:0] per_channel_irq_flags, chan_sel, chan_wr_data;
    logic [7:0] chan_soft_reset, eightfold_sampling_select;
    logic [7:0] fourfold_sampling_select, channel_sleep_enable;
    logic [23:0] chan_irq_code;
    logic [63:0] chan_rd_data;
    logic [3:0] chan_reg_index, counter_control_reg;
    logic [15:0] timer_reload;
    logic timer_timeout, chan_wr_strobe, chan_rd_strobe;
    logic chan_legacy_access, sleep_request, counter_control_read;
    int mismatches = 0, checks_done = 0;
    int wr_cnt = 0, rs_cnt = 0, cr_cnt = 0;
    logic [7:0] cap_sel, cap_data, cap_rs;
    logic [3:0] cap_idx;
    logic [7:0] sh [16];
    octal_uart_global_config_regs #(.REVISION_CODE(REV),
        .IDENTITY_CODE(IDC)) dut (.*);
    host_cpu_model u_host (.*);
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
    begin
        if (chan_wr_strobe === 1'b1)
        begin
            wr_cnt++;
            cap_sel = chan_sel;
            cap_idx = chan_reg_index;
            cap_data = chan_wr_data;
        end
        if (chan_rd_strobe === 1'b1)
            cap_sel = chan_sel;
        if (chan_soft_reset !== 8'h00)
        begin
            rs_cnt++;
            cap_rs = chan_soft_reset;
        end
        if (counter_control_read === 1'b1)
            cr_cnt++;
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_cnt(input int g, input int e);
        chk(8'(g), 8'(e));
    endtask
    function automatic logic [7:0] rw_mask(input logic [7:0] a);
        case (a)
            8'h84: return 8'h0f;
            8'h86, 8'h87, 8'h88, 8'h89, 8'h8b: return 8'hff;
            8'h8e: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        logic [23:0] c;
        c = chan_irq_code;
        if (timer_timeout === 1'b1 && c[2:0] == 3'h0)
            c[2:0] = 3'h7;
        case (a)
            8'h80: return per_channel_irq_flags | {7'h0, timer_timeout};
            8'h81: return c[7:0];
            8'h82: return c[15:8];
            8'h83: return c[23:16];
            8'h8c: return REV;
            8'h8d: return IDC;
            default: return sh[a[3:0]];
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic o;
        u_host.access(a, d, 1'b0, q, o);
        if (a[7:4] == 4'h8)
            sh[a[3:0]] = d & rw_mask(a);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic o;
        u_host.access(a, 8'($urandom), 1'b1, q, o);
        chk(8'(o), 8'h01);
    endtask
    task automatic scan_global();
        logic [7:0] q;
        for (int i = 0; i < 16; i++)
        begin
            rd({4'h8, 4'(i)}, q);
            chk(q, exp_rd({4'h8, 4'(i)}));
        end
    endtask
    initial
    begin
        logic [7:0] q, d, a, v;
        int n, m;
        logic [7:0] rw_tab [7] = '{8'h84, 8'h86, 8'h87, 8'h88, 8'h89,
            8'h8b, 8'h8e};
        logic [7:0] ro_tab [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h85,
            8'h8c, 8'h8d, 8'h8f};
        logic [7:0] sr_tab [4] = '{8'h01, 8'h80, 8'ha5, 8'h00};
        logic [7:0] far_tab [3] = '{8'h90, 8'hc7, 8'hff};
        rst = 1'b1;
        per_channel_irq_flags = 8'h00;
        chan_irq_code = 24'h000000;
        timer_timeout = 1'b0;
        chan_rd_data = 64'h0;
        sh = '{default: 8'h00};
        void'($urandom(32'he385));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk(eightfold_sampling_select | fourfold_sampling_select, 8'h00);
        scan_global();
        for (int r = 0; r < 3; r++)
            foreach (rw_tab[i])
            begin
                d = (r == 0) ? 8'hff : 8'($urandom);
                wr(rw_tab[i], d);
                rd(rw_tab[i], q);
                chk(q, d & rw_mask(rw_tab[i]));
            end
        chk(timer_reload[7:0], sh[6]);
        chk(timer_reload[15:8], sh[7]);
        chk(8'(counter_control_reg), sh[4]);
        chk(eightfold_sampling_select, sh[8]);
        chk(fourfold_sampling_select, sh[9]);
        chk(channel_sleep_enable, sh[11]);
        n = wr_cnt;
        m = rs_cnt;
        foreach (ro_tab[i]) wr(ro_tab[i], 8'($urandom));
        chk_cnt(wr_cnt - n + rs_cnt - m, 0);
        n = cr_cnt;
        rd(8'h84, q);
        chk_cnt(cr_cnt - n, 1);
        for (int it = 0; it < 6; it++)
        begin
            @(negedge ref_clk);
            for (int ch = 0; ch < 8; ch++)
                chan_irq_code[3*ch +: 3] = 3'((it + ch) % 5);
            per_channel_irq_flags = 8'($urandom);
            timer_timeout = ~it[0];
            scan_global();
        end
        foreach (sr_tab[i])
        begin
            n = rs_cnt;
            wr(8'h8a, sr_tab[i]);
            chk_cnt(rs_cnt - n, int'(sr_tab[i] != 8'h00));
            if (sr_tab[i] != 8'h00)
                chk(cap_rs, sr_tab[i]);
        end
        for (int ch = 0; ch < 8; ch++)
            for (int bc = 0; bc < 2; bc++)
            begin
                wr(8'h8e, 8'(bc));
                a = {1'b0, 3'(ch), 4'(ch * 2 + bc)};
                d = 8'($urandom);
                n = wr_cnt;
                wr(a, d);
                chk_cnt(wr_cnt - n, 1);
                chk(cap_sel, (bc == 1) ? 8'hff : 8'(1 << ch));
                chk(8'(cap_idx), 8'(a[3:0]));
                chk(cap_data, d);
                chk(8'(chan_legacy_access), 8'(!a[3]));
                chan_rd_data = {$urandom, $urandom};
                rd(a, q);
                chk(q, chan_rd_data[8*ch +: 8]);
                chk(cap_sel, 8'(1 << ch));
            end
        wr(8'h8e, 8'h00);
        foreach (far_tab[i])
        begin
            n = wr_cnt;
            wr(far_tab[i], 8'($urandom));
            rd(far_tab[i], q);
            chk(q, 8'h00);
            chk_cnt(wr_cnt - n, 0);
        end
        per_channel_irq_flags = 8'h00;
        timer_timeout = 1'b0;
        wr(8'h8b, 8'hff);
        repeat (4) @(negedge ref_clk);
        chk(8'(sleep_request), 8'h01);
        per_channel_irq_flags = 8'h10;
        repeat (4) @(negedge ref_clk);
        chk(8'(sleep_request), 8'h00);
        per_channel_irq_flags = 8'h00;
        wr(8'h8b, 8'h7f);
        chk(8'(sleep_request), 8'h00);
        wr(8'h8b, 8'h00);
        chk(8'(sleep_request), 8'h00);
        give_verdict();
    end
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end
endmodule
bind octal_uart_global_config_regs octal_gcr_checker u_chk (.*);
